// >>> rtl/dword_exec.v
// Execute stage for doubleword shift, subtract, exception return and jumps
// What this block does
// RQ1 - The fixed long right shift moves the source right by the field plus 32, zero filled.
// RQ2 - The variable right shift uses only the low six bits of the count register.
// RQ3 - The trapping subtract keeps the destination and raises overflow on signed overflow.
// RQ4 - The modulo subtract always writes the difference and never raises overflow.
// RQ5 - With the error-level bit set, return loads the error address and clears only that bit.
// RQ6 - With it clear, return loads the exception address and clears the exception-level bit.
// RQ7 - Exception return has no delay slot, so the next instruction is not executed.
// RQ8 - Exception return clears the load-linked flag.
// RQ9 - Region jumps join the delay-slot upper bits with the index shifted left by two.
// RQ10 - A jump in the last word of a region takes its target from the delay-slot region.
// RQ11 - Every jump executes the following instruction before transferring control.
// RQ12 - Region jump-and-link writes the jump address plus 8 into register 31.
// RQ13 - Register jumps take the target read before the link write, which is address plus 8.
// RQ14 - Only register jump-and-link selects its link register; region jump-and-link uses register 31.
// RQ15 - Register jump-and-link with equal source and destination has an undefined result.
// RQ16 - A misaligned register-jump target faults on the target fetch, not on the jump.
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`include "xexec_map.vh"
module dword_exec (
  // Clock and reset
  input  wire        CLK_SYS_I,
  input  wire        SYS_RST_I,
  // Issued instruction
  input  wire        ISSUE_VALID_I,
  input  wire [31:0] INSTR_I,
  input  wire [63:0] PC_I,
  input  wire [63:0] FIRST_SOURCE_I,
  input  wire [63:0] SECOND_SOURCE_I,
  // System state
  input  wire [31:0] STATUS_WORD_I,
  input  wire [63:0] EXCEPTION_RETURN_ADDRESS_I,
  input  wire [63:0] ERROR_RETURN_ADDRESS_I,
  // Fetch of the instruction after a jump
  input  wire        FETCH_VALID_I,
  input  wire [63:0] FETCH_PC_I,
  // Register write
  output reg         WR_EN_O,
  output reg  [4:0]  WR_REG_O,
  output reg  [63:0] WR_DATA_O,
  // Control flow and status
  output reg         PC_LOAD_O,
  output reg  [63:0] PC_NEXT_O,
  output reg         SLOT_EXEC_O,
  output reg         SKIP_NEXT_O,
  output reg         STATUS_WR_O,
  output reg  [31:0] STATUS_WORD_O,
  output reg         LOAD_LINKED_CLEAR_O,
  output reg         OVERFLOW_EXC_O,
  output reg         ADDRESS_ERROR_O,
  output reg  [63:0] BAD_ADDRESS_O,
  // Wishbone slave
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [3:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  // Interrupt
  output wire        IRQ_O
);
  // Instruction fields
  wire [5:0]  opcode = INSTR_I[31:26];
  wire [4:0]  src_a  = INSTR_I[25:21];
  wire [4:0]  dst    = INSTR_I[15:11];
  wire [4:0]  shift_amount_field = INSTR_I[10:6];
  wire [5:0]  funct  = INSTR_I[5:0];
  wire [25:0] index  = INSTR_I[25:0];
  wire        special = (opcode == `OP_SPECIAL);

  // Decoded operations, gated by the software enable
  reg  enable;
  wire go = ISSUE_VALID_I & enable;
  wire dword_shift_right_logical_plus32 = go & special & (funct == `FN_DWORD_SHIFT_RIGHT_LOGICAL_PLUS32);
  wire dword_shift_right_logical_variable = go & special & (funct == `FN_DWORD_SHIFT_RIGHT_LOGICAL_VARIABLE);
  wire dword_subtract_trapping = go & special & (funct == `FN_DWORD_SUBTRACT_TRAPPING);
  wire dword_subtract_modulo = go & special & (funct == `FN_DWORD_SUBTRACT_MODULO);
  wire register_jump = go & special & (funct == `FN_JR);
  wire register_jump_link = go & special & (funct == `FN_REGISTER_JUMP_LINK);
  wire region_jump = go & (opcode == `OP_JUMP);
  wire region_jump_link = go & (opcode == `OP_JUMP_LINK);
  wire exception_return = go & (opcode == `OP_COP0) & INSTR_I[25] & (funct == `FN_EXCEPTION_RETURN);
  wire any_jump = region_jump | region_jump_link | register_jump | register_jump_link;

  // Shift counts: fixed form is 32 plus field, variable uses the low six bits
  wire [5:0]  count_fixed = `SHIFT_PLUS32 | {1'b0, shift_amount_field}; // RQ1
  wire [5:0]  count_var   = FIRST_SOURCE_I[5:0]; // RQ2
  wire [63:0] shr_fixed   = SECOND_SOURCE_I >> count_fixed; // RQ1
  wire [63:0] shr_var     = SECOND_SOURCE_I >> count_var; // RQ2

  // Subtract and signed overflow
  wire [63:0] diff = FIRST_SOURCE_I - SECOND_SOURCE_I;
  wire        ovf  = (FIRST_SOURCE_I[63] != SECOND_SOURCE_I[63]) &
                     (diff[63] != FIRST_SOURCE_I[63]);

  // Link and targets
  wire [63:0] link_addr = PC_I + `LINK_OFFSET;
  wire [63:0] slot_pc   = PC_I + 64'h0000000000000004;
  wire [63:0] region_target = {slot_pc[63:28], index, 2'b00}; // RQ9 RQ10
  wire [63:0] reg_target = FIRST_SOURCE_I; // RQ13

  // Pending jump held across the delay slot
  reg         jump_pending;
  reg  [63:0] jump_target;
  reg         bad_link;

  // Software registers
  reg  [31:0] mask;
  wire [`EV_WIDTH-1:0] events;
  wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  // Writes take effect at the edge that samples ack high
  wire wb_wr  = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I & WB_SEL_I[0];
  wire clr_st = wb_wr & (WB_ADR_I == `REG_STATUS);
  wire [`EV_WIDTH-1:0] ev_set;
  assign ev_set[`EV_OVF]      = OVERFLOW_EXC_O;
  assign ev_set[`EV_ADDR_ERR] = ADDRESS_ERROR_O;
  assign ev_set[`EV_EXCEPTION_RETURN]     = LOAD_LINKED_CLEAR_O;
  assign ev_set[`EV_BAD_LINK] = bad_link;

  // Sticky event: trapping subtract overflowed
  sticky_event u_ev_ovf (
    .CLK_SYS_I (CLK_SYS_I),
    .SYS_RST_I (SYS_RST_I),
    .set_i     (ev_set[`EV_OVF]),
    .clear_i   (clr_st & WB_DAT_I[`EV_OVF]),
    .flag_o    (events[`EV_OVF])
  );

  // Sticky event: misaligned target fetched
  sticky_event u_ev_addr (
    .CLK_SYS_I (CLK_SYS_I),
    .SYS_RST_I (SYS_RST_I),
    .set_i     (ev_set[`EV_ADDR_ERR]),
    .clear_i   (clr_st & WB_DAT_I[`EV_ADDR_ERR]),
    .flag_o    (events[`EV_ADDR_ERR])
  );

  // Sticky event: exception return executed
  sticky_event u_ev_ret (
    .CLK_SYS_I (CLK_SYS_I),
    .SYS_RST_I (SYS_RST_I),
    .set_i     (ev_set[`EV_EXCEPTION_RETURN]),
    .clear_i   (clr_st & WB_DAT_I[`EV_EXCEPTION_RETURN]),
    .flag_o    (events[`EV_EXCEPTION_RETURN])
  );

  // Sticky event: register link with equal source and destination
  sticky_event u_ev_link (
    .CLK_SYS_I (CLK_SYS_I),
    .SYS_RST_I (SYS_RST_I),
    .set_i     (ev_set[`EV_BAD_LINK]),
    .clear_i   (clr_st & WB_DAT_I[`EV_BAD_LINK]),
    .flag_o    (events[`EV_BAD_LINK])
  );

  assign IRQ_O = |(events & mask[`EV_WIDTH-1:0]);

  // Next values of the result, write-back and control-flow registers
  reg         next_wr_en;
  reg  [4:0]  next_wr_reg;
  reg  [63:0] next_wr_data;
  reg         next_pc_load;
  reg  [63:0] next_pc_next;
  reg         next_slot_exec;
  reg         next_skip_next;
  reg         next_status_wr;
  reg  [31:0] next_status_word;
  reg         next_ll_clear;
  reg         next_overflow;
  reg         next_jump_pending;
  reg  [63:0] next_jump_target;
  reg         next_bad_link;

  // Decode of the issued word; pulses default low, data registers hold
  always @* begin
    next_wr_en = 1'b0;
    next_wr_reg = WR_REG_O;
    next_wr_data = WR_DATA_O;
    next_pc_load = 1'b0;
    next_pc_next = PC_NEXT_O;
    next_slot_exec = 1'b0;
    next_skip_next = 1'b0;
    next_status_wr = 1'b0;
    next_status_word = STATUS_WORD_O;
    next_ll_clear = 1'b0;
    next_overflow = 1'b0;
    next_jump_pending = jump_pending;
    next_jump_target = jump_target;
    next_bad_link = 1'b0;
    // Redirect after the delay-slot instruction has issued
    if (jump_pending & ISSUE_VALID_I) begin
      next_pc_load = 1'b1; // RQ11
      next_pc_next = jump_target;
      next_jump_pending = 1'b0;
    end
    // Fixed shift by 32 to 63
    if (dword_shift_right_logical_plus32) begin
      next_wr_en = 1'b1;
      next_wr_reg = dst;
      next_wr_data = shr_fixed; // RQ1
    end
    // Variable shift by the low six count bits
    if (dword_shift_right_logical_variable) begin
      next_wr_en = 1'b1;
      next_wr_reg = dst;
      next_wr_data = shr_var; // RQ2
    end
    // Trapping subtract keeps the destination on overflow
    if (dword_subtract_trapping) begin
      next_wr_en = ~ovf; // RQ3
      next_wr_reg = dst;
      next_wr_data = diff;
      next_overflow = ovf; // RQ3
    end
    // Modulo subtract always writes
    if (dword_subtract_modulo) begin
      next_wr_en = 1'b1; // RQ4
      next_wr_reg = dst;
      next_wr_data = diff;
    end
    // Exception return: no delay slot, and a pending jump is dropped
    if (exception_return) begin
      next_pc_load = 1'b1;
      next_skip_next = 1'b1; // RQ7
      next_status_wr = 1'b1;
      next_ll_clear = 1'b1; // RQ8
      next_jump_pending = 1'b0;
      if (STATUS_WORD_I[`SR_ERL_BIT]) begin
        next_pc_next = ERROR_RETURN_ADDRESS_I; // RQ5
        next_status_word = STATUS_WORD_I & ~(32'h00000001 << `SR_ERL_BIT); // RQ5
      end else begin
        next_pc_next = EXCEPTION_RETURN_ADDRESS_I; // RQ6
        next_status_word = STATUS_WORD_I & ~(32'h00000001 << `SR_EXL_BIT); // RQ6
      end
    end
    // Any jump: remember the target until its delay slot has issued
    if (any_jump) begin
      next_jump_pending = 1'b1;
      next_slot_exec = 1'b1; // RQ11
      next_jump_target = (register_jump | register_jump_link) ? reg_target : region_target;
    end
    // Region link always goes to register 31
    if (region_jump_link) begin
      next_wr_en = 1'b1;
      next_wr_reg = `LINK_REG; // RQ12 RQ14
      next_wr_data = link_addr; // RQ12
    end
    // Register link goes to the selected register; equal numbers are flagged
    if (register_jump_link) begin
      next_wr_en = 1'b1;
      next_wr_reg = dst; // RQ14
      next_wr_data = link_addr; // RQ13
      next_bad_link = (src_a == dst); // RQ15
    end
  end

  // Result, write-back and control-flow registers
  always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      WR_EN_O <= 1'b0;
      WR_REG_O <= 5'h00;
      WR_DATA_O <= 64'h0000000000000000;
      PC_LOAD_O <= 1'b0;
      PC_NEXT_O <= 64'h0000000000000000;
      SLOT_EXEC_O <= 1'b0;
      SKIP_NEXT_O <= 1'b0;
      STATUS_WR_O <= 1'b0;
      STATUS_WORD_O <= 32'h00000000;
      LOAD_LINKED_CLEAR_O <= 1'b0;
      OVERFLOW_EXC_O <= 1'b0;
      jump_pending <= 1'b0;
      jump_target <= 64'h0000000000000000;
      bad_link <= 1'b0;
    end else begin
      WR_EN_O <= next_wr_en;
      WR_REG_O <= next_wr_reg;
      WR_DATA_O <= next_wr_data;
      PC_LOAD_O <= next_pc_load;
      PC_NEXT_O <= next_pc_next;
      SLOT_EXEC_O <= next_slot_exec;
      SKIP_NEXT_O <= next_skip_next;
      STATUS_WR_O <= next_status_wr;
      STATUS_WORD_O <= next_status_word;
      LOAD_LINKED_CLEAR_O <= next_ll_clear;
      OVERFLOW_EXC_O <= next_overflow;
      jump_pending <= next_jump_pending;
      jump_target <= next_jump_target;
      bad_link <= next_bad_link;
    end
  end

  // Address error is raised when the redirected target is fetched, not at the jump
  wire        fetch_misaligned = FETCH_VALID_I & (FETCH_PC_I[1:0] != 2'b00); // RQ16
  reg         next_addr_err;
  reg  [63:0] next_bad_addr;

  // Fault capture: the faulting address holds until the next fault
  always @* begin
    next_addr_err = fetch_misaligned; // RQ16
    next_bad_addr = BAD_ADDRESS_O;
    if (fetch_misaligned)
      next_bad_addr = FETCH_PC_I;
  end

  // Fault registers
  always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      ADDRESS_ERROR_O <= 1'b0;
      BAD_ADDRESS_O <= 64'h0000000000000000;
    end else begin
      ADDRESS_ERROR_O <= next_addr_err;
      BAD_ADDRESS_O <= next_bad_addr;
    end
  end

  // Next values of the bus-side registers
  reg  [31:0] next_mask;
  reg         next_enable;
  reg  [31:0] next_wb_dat;

  // Writes land with ack; read data is latched when the request is taken
  always @* begin
    next_mask = mask;
    next_enable = enable;
    next_wb_dat = WB_DAT_O;
    if (wb_wr & (WB_ADR_I == `REG_MASK))
      next_mask = {28'h0000000, WB_DAT_I[3:0]};
    if (wb_wr & (WB_ADR_I == `REG_CONTROL))
      next_enable = WB_DAT_I[0];
    if (wb_req & ~WB_WE_I) begin
      case (WB_ADR_I)
        `REG_STATUS:  next_wb_dat = {28'h0000000, events};
        `REG_MASK:    next_wb_dat = mask;
        `REG_CONTROL: next_wb_dat = {30'h00000000, jump_pending, enable};
        `REG_PC:      next_wb_dat = PC_NEXT_O[31:0];
        default:      next_wb_dat = 32'h00000000;
      endcase
    end
  end

  // Wishbone slave registers: ack one cycle after the request is taken
  always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      mask <= 32'h00000000;
      enable <= `CTRL_RESET;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= next_wb_dat;
      mask <= next_mask;
      enable <= next_enable;
    end
  end
endmodule // dword_exec

// >>> rtl/xexec_map.vh
// Opcode, function, status bit and register bus constants for the execute block
`ifndef XEXEC_MAP_VH
`define XEXEC_MAP_VH
// Primary opcodes and function codes
`define OP_SPECIAL     6'h00
`define OP_JUMP        6'h02
`define OP_JUMP_LINK   6'h03
`define OP_COP0        6'h10
`define FN_JR          6'h08
`define FN_REGISTER_JUMP_LINK        6'h09
`define FN_DWORD_SHIFT_RIGHT_LOGICAL_VARIABLE       6'h16
`define FN_DWORD_SUBTRACT_TRAPPING        6'h2E
`define FN_DWORD_SUBTRACT_MODULO       6'h2F
`define FN_DWORD_SHIFT_RIGHT_LOGICAL_PLUS32      6'h3E
`define FN_EXCEPTION_RETURN        6'h18
// Status word fields
`define SR_EXL_BIT     1
`define SR_ERL_BIT     2
// Link register, link offset and long-shift base
`define LINK_REG       5'h1F
`define LINK_OFFSET    64'h0000000000000008
`define SHIFT_PLUS32   6'h20
// Register offsets (byte addresses)
`define REG_STATUS     4'h0
`define REG_MASK       4'h4
`define REG_CONTROL    4'h8
`define REG_PC         4'hC
// Event bits and control reset value
`define EV_OVF         0
`define EV_ADDR_ERR    1
`define EV_EXCEPTION_RETURN        2
`define EV_BAD_LINK    3
`define EV_WIDTH       4
`define CTRL_RESET     1'b1
`endif

// >>> rtl/sticky_event.v
// One sticky event bit, set by hardware and cleared by writing a one
module sticky_event (
  // Clock and reset
  input  wire CLK_SYS_I,
  input  wire SYS_RST_I,
  // Set and clear
  input  wire set_i,
  input  wire clear_i,
  // State
  output reg  flag_o
);
  // Set wins over a clear in the same cycle
  always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I)
      flag_o <= 1'b0;
    else if (set_i)
      flag_o <= 1'b1;
    else if (clear_i)
      flag_o <= 1'b0;
  end
endmodule // sticky_event

// >>> tb/dword_exec_sva.sv
// Assertion checker for the doubleword execute block
module dword_exec_sva (
  input wire        CLK_SYS_I, SYS_RST_I, ISSUE_VALID_I, FETCH_VALID_I, WB_CYC_I, WB_STB_I,
  input wire [31:0] INSTR_I, STATUS_WORD_I, STATUS_WORD_O,
  input wire [63:0] PC_I, FIRST_SOURCE_I, SECOND_SOURCE_I, FETCH_PC_I, PC_NEXT_O, WR_DATA_O,
  input wire [63:0] EXCEPTION_RETURN_ADDRESS_I, ERROR_RETURN_ADDRESS_I, BAD_ADDRESS_O,
  input wire        WR_EN_O, PC_LOAD_O, SKIP_NEXT_O, LOAD_LINKED_CLEAR_O, OVERFLOW_EXC_O,
  input wire        ADDRESS_ERROR_O, WB_ACK_O,
  input wire [4:0]  WR_REG_O
);
  // Decode of the issued word
  wire        sp  = ISSUE_VALID_I && INSTR_I[31:26] == 6'h00;
  wire [5:0]  fn  = INSTR_I[5:0];
  wire [4:0]  sa  = INSTR_I[10:6];
  wire [4:0]  rd  = INSTR_I[15:11];
  wire        ret = ISSUE_VALID_I && INSTR_I == 32'h42000018;
  wire        rj  = ISSUE_VALID_I && INSTR_I[31:27] == 5'h01;
  wire [63:0] dif = FIRST_SOURCE_I - SECOND_SOURCE_I;
  wire [63:0] nxt = PC_I + 64'h0000000000000004;
  wire        ovf = FIRST_SOURCE_I[63] != SECOND_SOURCE_I[63] && dif[63] != FIRST_SOURCE_I[63];
  reg  [63:0] tgt;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  // Region target built from the delay-slot address
  always @(posedge CLK_SYS_I) begin
    if (rj) tgt <= {nxt[63:28], INSTR_I[25:0], 2'b00};
  end
  sequence s_jump_slot;
    rj ##1 ISSUE_VALID_I;
  endsequence
  chk_shift_plus32: assert property (sp && fn == 6'h3E |=> WR_EN_O &&
    WR_DATA_O == $past(SECOND_SOURCE_I) >> (7'h20 + $past(sa))) else $error("shift32 wrong");
  chk_sub_trap: assert property (sp && fn == 6'h2E && ovf |=> OVERFLOW_EXC_O && !WR_EN_O)
    else $error("trap subtract wrong");
  chk_sub_modulo: assert property (sp && fn == 6'h2F |=> WR_EN_O && !OVERFLOW_EXC_O &&
    WR_DATA_O == $past(dif)) else $error("modulo subtract wrong");
  chk_ret_error: assert property (ret && STATUS_WORD_I[2] |=> PC_LOAD_O && SKIP_NEXT_O &&
    PC_NEXT_O == $past(ERROR_RETURN_ADDRESS_I) &&
    STATUS_WORD_O == ($past(STATUS_WORD_I) & 32'hFFFFFFFB)) else $error("error return wrong");
  chk_ret_exc: assert property (ret && !STATUS_WORD_I[2] |=> LOAD_LINKED_CLEAR_O &&
    PC_NEXT_O == $past(EXCEPTION_RETURN_ADDRESS_I) &&
    STATUS_WORD_O == ($past(STATUS_WORD_I) & 32'hFFFFFFFD)) else $error("return wrong");
  chk_region_target: assert property (s_jump_slot |=> PC_LOAD_O && PC_NEXT_O == tgt)
    else $error("region target wrong");
  chk_link_fixed: assert property (ISSUE_VALID_I && INSTR_I[31:26] == 6'h03 |=> WR_EN_O &&
    WR_REG_O == 5'h1F && WR_DATA_O == $past(PC_I) + 64'h8) else $error("link wrong");
  chk_link_select: assert property (sp && fn == 6'h09 && !FETCH_VALID_I |=>
    WR_REG_O == $past(rd) && !ADDRESS_ERROR_O) else $error("register link wrong");
  chk_fetch_fault: assert property (FETCH_VALID_I && FETCH_PC_I[1:0] != 2'b00 |=>
    ADDRESS_ERROR_O && BAD_ADDRESS_O == $past(FETCH_PC_I)) else $error("fetch fault wrong");
  chk_bus_ack: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack timing wrong");
endmodule // dword_exec_sva
bind dword_exec dword_exec_sva chk (.*);

// >>> tb/dword_shift_sub_jump_exec_tb.sv
// Self-checking bench for the doubleword execute block
module dword_shift_sub_jump_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus, answers and counters
  logic        CLK_SYS_I = 1'b0, SYS_RST_I = 1'b1, ISSUE_VALID_I = 1'b0, FETCH_VALID_I = 1'b0;
  logic        WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
  logic [3:0]  WB_ADR_I = '0, WB_SEL_I = '0;
  logic [31:0] INSTR_I = '0, STATUS_WORD_I = '0, WB_DAT_I = '0, q;
  logic [63:0] PC_I = '0, FIRST_SOURCE_I = '0, SECOND_SOURCE_I = '0, FETCH_PC_I = '0;
  logic [63:0] EXCEPTION_RETURN_ADDRESS_I = 64'h80000180, ERROR_RETURN_ADDRESS_I = 64'hBFC00380;
  wire         WR_EN_O, PC_LOAD_O, SLOT_EXEC_O, SKIP_NEXT_O, STATUS_WR_O, LOAD_LINKED_CLEAR_O;
  wire         OVERFLOW_EXC_O, ADDRESS_ERROR_O, WB_ACK_O, IRQ_O;
  wire [4:0]   WR_REG_O;
  wire [31:0]  STATUS_WORD_O, WB_DAT_O;
  wire [63:0]  WR_DATA_O, PC_NEXT_O, BAD_ADDRESS_O;
  int          err_total = 0, samples_checked = 0;
  dword_exec uut (.*);
  always #2 CLK_SYS_I = ~CLK_SYS_I;
  task automatic cmp(input string nm, input logic [71:0] ex, got);
    samples_checked++;
    if (got !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Issue a word; valid stays up until the next issue or idle
  task automatic iss(input logic [31:0] i, input logic [63:0] p, a, b);
    @(posedge CLK_SYS_I);
    {ISSUE_VALID_I, INSTR_I, PC_I, FIRST_SOURCE_I, SECOND_SOURCE_I} <= {1'b1, i, p, a, b};
  endtask
  task automatic idle;
    @(posedge CLK_SYS_I);
    ISSUE_VALID_I <= 1'b0;
    #1;
  endtask
  // One classic bus cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_SYS_I);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} <= {2'b11, we, a, 4'hF, d};
    do @(posedge CLK_SYS_I); while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'b00;
    #1;
  endtask
  task automatic sub(input logic [5:0] f, input logic [63:0] a, b, d, input logic [1:0] fl);
    iss({16'h0022, 5'h04, 5'h00, f}, '0, a, b);
    idle;
    cmp("sub flags", fl, {OVERFLOW_EXC_O, WR_EN_O});
    if (fl[0]) cmp("sub data", d, WR_DATA_O);
  endtask
  task automatic t_shift;
    iss({16'h0002, 5'h03, 5'h1F, 6'h3E}, '0, '0, 64'h8000000000000000);
    idle;
    cmp("shift63", {5'h03, 64'h1}, {WR_REG_O, WR_DATA_O});
    iss({16'h0002, 5'h03, 5'h00, 6'h3E}, '0, '0, 64'hFEDCBA9876543210);
    iss({16'h0022, 5'h03, 5'h00, 6'h16}, '0, 64'hFFFFFFFFFFFFFFC4, 64'hFEDCBA9876543210);
    #1;
    cmp("shift32", 64'h00000000FEDCBA98, WR_DATA_O);
    idle;
    cmp("shiftvar", 64'h0FEDCBA987654321, WR_DATA_O);
    $display("shift test done");
  endtask
  task automatic t_sub_irq;
    sub(6'h2E, 64'h8000000000000000, 64'h1, '0, 2'b10);
    sub(6'h2F, 64'h8000000000000000, 64'h1, 64'h7FFFFFFFFFFFFFFF, 2'b01);
    sub(6'h2E, 64'h5, 64'h7, 64'hFFFFFFFFFFFFFFFE, 2'b01);
    wb(1'b0, 4'h0, '0);
    cmp("event status", {32'h1, 1'b0}, {q, IRQ_O});
    wb(1'b1, 4'h4, 32'h00000001);
    cmp("irq unmasked", 1'b1, IRQ_O);
    wb(1'b1, 4'h0, 32'h00000001);
    cmp("irq cleared", 1'b0, IRQ_O);
    wb(1'b0, 4'h2, '0);
    cmp("unmapped", 32'h0, q);
    wb(1'b0, 4'h8, '0);
    cmp("control", 32'h1, q);
    $display("subtract and interrupt test done");
  endtask
  task automatic t_ret;
    logic [31:0] st [2] = '{32'h0000000F, 32'h00000013};
    for (int k = 0; k < 2; k++) begin
      iss(32'h42000018, 64'h100, '0, '0);
      STATUS_WORD_I <= st[k];
      idle;
      cmp("ret pc", st[k][2] ? 64'hBFC00380 : 64'h80000180, PC_NEXT_O);
      cmp("ret sr", st[k] & (st[k][2] ? 32'hFFFFFFFB : 32'hFFFFFFFD), STATUS_WORD_O);
      cmp("ret flags", 4'hF, {PC_LOAD_O, SKIP_NEXT_O, LOAD_LINKED_CLEAR_O, STATUS_WR_O});
    end
    $display("return test done");
  endtask
  task automatic t_jump;
    logic [31:0] ins [5] = '{32'h08000010, 32'h0C000010, 32'h00202809, 32'h00200008,
                             32'h00200809};
    logic [63:0] pc [5] = '{64'h0FFFFFFC, 64'h0FFFFFFC, 64'h2000, 64'h3000, 64'h5000};
    logic [63:0] tg [5] = '{64'h10000040, 64'h10000040, 64'h1235, 64'h4000, 64'h6000};
    logic [4:0]  rg [5] = '{5'h00, 5'h1F, 5'h05, 5'h00, 5'h01};
    for (int k = 0; k < 5; k++) begin
      iss(ins[k], pc[k], tg[k], '0);
      iss({16'h0022, 5'h06, 5'h00, 6'h2F}, pc[k] + 64'h4, 64'h9, 64'h2);
      #1;
      cmp("jump flags", {rg[k] != 5'h00, 2'b10}, {WR_EN_O, SLOT_EXEC_O, ADDRESS_ERROR_O});
      if (rg[k] != 5'h00) cmp("link", {rg[k], pc[k] + 64'h8}, {WR_REG_O, WR_DATA_O});
      idle;
      cmp("target", {1'b1, tg[k]}, {PC_LOAD_O, PC_NEXT_O});
      cmp("slot", {5'h06, 64'h7}, {WR_REG_O, WR_DATA_O});
    end
    @(posedge CLK_SYS_I);
    {FETCH_VALID_I, FETCH_PC_I} <= {1'b1, 64'h1235};
    @(posedge CLK_SYS_I);
    FETCH_VALID_I <= 1'b0;
    #1;
    cmp("fetch fault", {1'b1, 64'h1235}, {ADDRESS_ERROR_O, BAD_ADDRESS_O});
    wb(1'b0, 4'h0, '0);
    cmp("events after jumps", {32'h0000000E, 1'b0}, {q, IRQ_O});
    $display("jump test done");
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (3) @(posedge CLK_SYS_I);
    SYS_RST_I <= 1'b0;
    t_shift;
    t_sub_irq;
    t_ret;
    t_jump;
    wrap_up;
  end
  // Watchdog against a hung handshake
  initial begin
    #8000;
    err_total++;
    wrap_up;
  end
endmodule // dword_shift_sub_jump_exec_tb
